// >>> src/srtc_bank.sv
// register bank: reference pre-divider and two termination groups.
// assumes single-cycle reads/writes from the serial configuration port.
`timescale 1ns/1ns
`include "srtc_cfg.svh"

module srtc_bank #(
  parameter int CAL_BITS = 6
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pll_ref_clk,
  output logic ref_div_clk,
  input wire logic [2:0] term_cal_result_a,
  input wire logic [2:0] term_cal_result_b,
  output logic [2:0] term_value_lane [0:7],
  output logic term_cal_busy_a,
  output logic term_cal_busy_b
);

  if (CAL_BITS < 6) begin : g_bad_cal_bits
    $error("CAL_BITS too small for calibration time");
  end

  // ==========================================================
  // register storage
  logic [1:0] ref_predivide_select;
  logic term_cal_start_group_a;
  logic term_cal_start_group_b;
  logic [7:0] term_override_group_a;
  logic [7:0] term_override_group_b;
  logic [3:0] term_code_readback_group_a;
  logic [3:0] term_code_readback_group_b;

  wire wr_prediv = reg_wr && reg_addr == `SRTC_ADDR_PREDIV;
  wire wr_a_start = reg_wr && reg_addr == `SRTC_ADDR_A_START;
  wire wr_a_ovr = reg_wr && reg_addr == `SRTC_ADDR_A_OVR;
  wire wr_b_start = reg_wr && reg_addr == `SRTC_ADDR_B_START;
  wire wr_b_ovr = reg_wr && reg_addr == `SRTC_ADDR_B_OVR;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_predivide_select <= '0;
      term_cal_start_group_a <= 1'b0;
      term_cal_start_group_b <= 1'b0;
      term_override_group_a <= `SRTC_RST_VAL;
      term_override_group_b <= `SRTC_RST_VAL;
    end else begin
      if (wr_prediv)
        ref_predivide_select <= reg_wdata[`SRTC_PREDIV_HI:0];
      if (wr_a_start)
        term_cal_start_group_a <= reg_wdata[`SRTC_START_BIT];
      if (wr_b_start)
        term_cal_start_group_b <= reg_wdata[`SRTC_START_BIT];
      if (wr_a_ovr)
        term_override_group_a <= reg_wdata;
      if (wr_b_ovr)
        term_override_group_b <= reg_wdata;
    end
  end

  // ==========================================================
  // read mux; unmapped addresses and reserved select, start and readback bits read zero; override registers read back all 8 bits as written
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = `SRTC_RST_VAL;
    unique case (reg_addr)
      `SRTC_ADDR_PREDIV: next_rdata = {6'h00, ref_predivide_select};
      `SRTC_ADDR_A_START: next_rdata = {7'h00, term_cal_start_group_a};
      `SRTC_ADDR_A_OVR: next_rdata = term_override_group_a;
      `SRTC_ADDR_A_RB: next_rdata = {4'h0, term_code_readback_group_a}; // [R10]
      `SRTC_ADDR_B_START: next_rdata = {7'h00, term_cal_start_group_b};
      `SRTC_ADDR_B_OVR: next_rdata = term_override_group_b;
      default: next_rdata = `SRTC_RST_VAL;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      reg_rdata <= `SRTC_RST_VAL;
    else
      reg_rdata <= next_rdata;
  end

  // ==========================================================
  // reference pre-divider: a counter on the reference clock
  // reset and select are retimed into the reference clock domain;
  // the select only moves on after two matching samples, so a
  // half-changed two-bit word never reaches the divider
  logic ref_rst_meta_n;
  logic ref_rst_n;
  logic [1:0] ref_cnt;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic [1:0] sel_prev;
  logic [1:0] ref_sel_sync;

  always_ff @(posedge pll_ref_clk) begin
    ref_rst_meta_n <= rst_n;
    ref_rst_n <= ref_rst_meta_n;
  end

  always_ff @(posedge pll_ref_clk) begin
    sel_meta <= ref_predivide_select;
    sel_sync <= sel_meta;
    sel_prev <= sel_sync;
  end

  always_ff @(posedge pll_ref_clk) begin
    if (!ref_rst_n) begin
      ref_cnt <= '0;
      ref_sel_sync <= `SRTC_DIV_SEL_4;
    end else begin
      ref_cnt <= ref_cnt + 2'h1;
      if (sel_sync == sel_prev)
        ref_sel_sync <= sel_sync;
    end
  end

  // divide select driving ref_div_clk
  always_comb begin
    unique case (ref_sel_sync)
      `SRTC_DIV_SEL_1: ref_div_clk = pll_ref_clk; // [R5] [R2]
      `SRTC_DIV_SEL_2: ref_div_clk = ref_cnt[0]; // [R2]
      default: ref_div_clk = ref_cnt[1]; // [R2]
    endcase
  end

  // ==========================================================
  // calibration engines, one per group
  logic start_a_q;
  logic start_b_q;
  srtc_pkg::srtc_cal_e state_a;
  srtc_pkg::srtc_cal_e state_b;
  logic [CAL_BITS-1:0] cnt_a;
  logic [CAL_BITS-1:0] cnt_b;

  wire launch_a = term_cal_start_group_a && !start_a_q; // [R6] [R11]
  wire launch_b = term_cal_start_group_b && !start_b_q; // [R6] [R11]
  wire cal_end_a = cnt_a == CAL_BITS'(`SRTC_CAL_CYCLES);
  wire cal_end_b = cnt_b == CAL_BITS'(`SRTC_CAL_CYCLES);

  function automatic srtc_pkg::srtc_cal_e next_cal(
    input srtc_pkg::srtc_cal_e st, input logic go, input logic fin);
    next_cal = st;
    unique case (st)
      srtc_pkg::CAL_IDLE: if (go) next_cal = srtc_pkg::CAL_RUN;
      srtc_pkg::CAL_RUN: if (fin) next_cal = srtc_pkg::CAL_DONE;
      srtc_pkg::CAL_DONE: if (go) next_cal = srtc_pkg::CAL_RUN;
      default: next_cal = srtc_pkg::CAL_IDLE;
    endcase
  endfunction

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      start_a_q <= 1'b0;
      start_b_q <= 1'b0;
      state_a <= srtc_pkg::CAL_IDLE;
      state_b <= srtc_pkg::CAL_IDLE;
      cnt_a <= '0;
      cnt_b <= '0;
      term_code_readback_group_a <= 4'h0;
      term_code_readback_group_b <= 4'h0;
    end else begin
      start_a_q <= term_cal_start_group_a;
      start_b_q <= term_cal_start_group_b;
      state_a <= next_cal(state_a, launch_a, cal_end_a);
      state_b <= next_cal(state_b, launch_b, cal_end_b);
      cnt_a <= (state_a == srtc_pkg::CAL_RUN && !launch_a) ?
               cnt_a + CAL_BITS'(1) : '0;
      cnt_b <= (state_b == srtc_pkg::CAL_RUN && !launch_b) ?
               cnt_b + CAL_BITS'(1) : '0;
      if (state_a == srtc_pkg::CAL_RUN && cal_end_a)
        term_code_readback_group_a <= {1'b0, term_cal_result_a}; // [R10]
      if (state_b == srtc_pkg::CAL_RUN && cal_end_b)
        term_code_readback_group_b <= {1'b0, term_cal_result_b};
    end
  end

  assign term_cal_busy_a = state_a == srtc_pkg::CAL_RUN;
  assign term_cal_busy_b = state_b == srtc_pkg::CAL_RUN;

  // ==========================================================
  // termination value per group, then to lanes
  wire srtc_pkg::srtc_code_t value_a = term_override_group_a[`SRTC_OVR_EN_BIT]
    ? term_override_group_a[`SRTC_OVR_VAL_HI:`SRTC_OVR_VAL_LO] // [R8]
    : term_code_readback_group_a[2:0]; // [R7]
  wire srtc_pkg::srtc_code_t value_b = term_override_group_b[`SRTC_OVR_EN_BIT]
    ? term_override_group_b[`SRTC_OVR_VAL_HI:`SRTC_OVR_VAL_LO] // [R8]
    : term_code_readback_group_b[2:0]; // [R7]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++)
        term_value_lane[i] <= 3'h0;
    end else begin
      for (int i = 0; i < 8; i++)
        term_value_lane[i] <= (i >= 2 && i <= 5) ? value_b : value_a; // [R9]
    end
  end

  // ==========================================================
  // checks
  property p_launch_once;
    @(posedge mclk) disable iff (!rst_n)
      launch_a |=> !launch_a;
  endproperty
  a_launch_once: assert property (p_launch_once) // [R11]
    else $error("start launched twice in a row");

  property p_start_runs;
    @(posedge mclk) disable iff (!rst_n)
      $rose(term_cal_start_group_a) |=> term_cal_busy_a;
  endproperty
  a_start_runs: assert property (p_start_runs) // [R6]
    else $error("start edge did not launch calibration");

  property p_held_no_retrig;
    @(posedge mclk) disable iff (!rst_n)
      (term_cal_start_group_b && start_b_q) |-> !launch_b;
  endproperty
  a_held_no_retrig: assert property (p_held_no_retrig) // [R11]
    else $error("held start bit retriggered");

  property p_force;
    @(posedge mclk) disable iff (!rst_n)
      term_override_group_a[4] |=> term_value_lane[0] ==
        $past(term_override_group_a[3:1]);
  endproperty
  a_force: assert property (p_force) // [R8]
    else $error("forced value not applied to lane 0");

  property p_auto;
    @(posedge mclk) disable iff (!rst_n)
      !term_override_group_b[4] |=> term_value_lane[3] ==
        $past(term_code_readback_group_b[2:0]);
  endproperty
  a_auto: assert property (p_auto) // [R7]
    else $error("calibrated value not used on lane 3");

  property p_groups;
    @(posedge mclk) disable iff (!rst_n)
      term_value_lane[6] == term_value_lane[1] &&
      term_value_lane[2] == term_value_lane[5];
  endproperty
  a_groups: assert property (p_groups) // [R9]
    else $error("lane grouping broken");

  property p_readback;
    @(posedge mclk) disable iff (!rst_n)
      reg_addr == `SRTC_ADDR_A_RB |=> reg_rdata[7:4] == 4'h0 &&
        reg_rdata[3:0] == $past(term_code_readback_group_a);
  endproperty
  a_readback: assert property (p_readback) // [R10]
    else $error("readback register wrong");

  property p_cal_len;
    @(posedge mclk) disable iff (!rst_n)
      $rose(term_cal_busy_a) |-> term_cal_busy_a [*8];
  endproperty
  a_cal_len: assert property (p_cal_len) // [R6]
    else $error("calibration ended too early");

  property p_div_sel;
    @(posedge mclk) disable iff (!rst_n)
      wr_prediv |=> ref_predivide_select == $past(reg_wdata[1:0]);
  endproperty
  a_div_sel: assert property (p_div_sel) // [R2] [R5]
    else $error("divide select not stored");

  property p_start_runs_b;
    @(posedge mclk) disable iff (!rst_n)
      $rose(term_cal_start_group_b) |=> term_cal_busy_b;
  endproperty
  a_start_runs_b: assert property (p_start_runs_b) // [R6]
    else $error("group b start edge did not launch calibration");

  property p_cal_len_b;
    @(posedge mclk) disable iff (!rst_n)
      $rose(term_cal_busy_b) |-> term_cal_busy_b [*8];
  endproperty
  a_cal_len_b: assert property (p_cal_len_b) // [R6]
    else $error("group b calibration ended too early");

  property p_force_b;
    @(posedge mclk) disable iff (!rst_n)
      term_override_group_b[`SRTC_OVR_EN_BIT] |=> term_value_lane[4] ==
        $past(term_override_group_b[`SRTC_OVR_VAL_HI:`SRTC_OVR_VAL_LO]);
  endproperty
  a_force_b: assert property (p_force_b) // [R8]
    else $error("forced value not applied to lane 4");

  property p_auto_a;
    @(posedge mclk) disable iff (!rst_n)
      !term_override_group_a[`SRTC_OVR_EN_BIT] |=> term_value_lane[7] ==
        $past(term_code_readback_group_a[2:0]);
  endproperty
  a_auto_a: assert property (p_auto_a) // [R7]
    else $error("calibrated value not used on lane 7");

  property p_code_latch;
    @(posedge mclk) disable iff (!rst_n)
      (term_cal_busy_a && cal_end_a) |=> term_code_readback_group_a ==
        {1'b0, $past(term_cal_result_a)};
  endproperty
  a_code_latch: assert property (p_code_latch) // [R10]
    else $error("calibration result not captured");

  property p_groups_more;
    @(posedge mclk) disable iff (!rst_n)
      term_value_lane[0] == term_value_lane[7] &&
      term_value_lane[3] == term_value_lane[4];
  endproperty
  a_groups_more: assert property (p_groups_more) // [R9]
    else $error("lane grouping broken on lanes 0/7 or 3/4");

endmodule

// >>> src/srtc_cfg.svh
// register addresses, field positions, divide selects and reset values for the
// serial-lane reference pre-divider and termination calibration bank.
// assumes a byte-wide register port with 10-bit addresses.
// Operation
// R1: software keeps reference over factor within 35-80 MHz
// R2: divide pll reference by two-bit field factor
// R3: software picks divide four for 6-12.5 Gbps
// R4: software picks divide two for 3-6 Gbps
// R5: field value 10 selects divide by one
// R6: start bit rising edge launches group calibration
// R7: override bit 4 low uses calibrated value
// R8: override bit 4 high forces bits 3:1
// R9: group a lanes 0,1,6,7; b lanes 2-5
// R10: group a result in readback low nibble
// R11: held start bit never retriggers calibration
`ifndef SRTC_CFG_SVH
`define SRTC_CFG_SVH

`define SRTC_ADDR_PREDIV 10'h289
`define SRTC_ADDR_A_START 10'h2a7
`define SRTC_ADDR_A_OVR 10'h2a8
`define SRTC_ADDR_A_RB 10'h2ac
`define SRTC_ADDR_B_START 10'h2ae
`define SRTC_ADDR_B_OVR 10'h2af
`define SRTC_RST_VAL 8'h00
`define SRTC_PREDIV_HI 1
`define SRTC_START_BIT 0
`define SRTC_OVR_EN_BIT 4
`define SRTC_OVR_VAL_HI 3
`define SRTC_OVR_VAL_LO 1
`define SRTC_DIV_SEL_1 2'h2
`define SRTC_DIV_SEL_2 2'h1
`define SRTC_DIV_SEL_4 2'h0
`define SRTC_CAL_CYCLES 6'h20

`endif

// >>> src/srtc_pkg.sv
// shared types of the termination calibration bank.
// assumes srtc_cfg.svh supplies the numeric constants.
package srtc_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} srtc_cal_e;
  typedef logic [2:0] srtc_code_t;
endpackage

// >>> test/srtc_bank_bench.sv
// ==========================================
// bench for the pre-divider and termination calibration bank
// assumes srtc_cfg.svh gives the register map; no partner model
`timescale 1ns/1ns
`include "srtc_cfg.svh"

module srtc_bank_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic pll_ref_clk = 1'b0;
  logic ref_div_clk;
  logic [2:0] term_cal_result_a = 3'h5;
  logic [2:0] term_cal_result_b = 3'h3;
  logic [2:0] term_value_lane [0:7];
  logic term_cal_busy_a;
  logic term_cal_busy_b;
  int fails = 0;
  int total_checks = 0;

  always #25 mclk = ~mclk;
  always #8 pll_ref_clk = ~pll_ref_clk;

  srtc_bank #(.CAL_BITS(6)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pll_ref_clk(pll_ref_clk),
    .ref_div_clk(ref_div_clk), .term_cal_result_a(term_cal_result_a),
    .term_cal_result_b(term_cal_result_b),
    .term_value_lane(term_value_lane), .term_cal_busy_a(term_cal_busy_a),
    .term_cal_busy_b(term_cal_busy_b));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic lanes_chk(input logic [2:0] ea, input logic [2:0] eb);
    for (int i = 0; i < 8; i++) begin
      chk({5'h00, term_value_lane[i]}, {5'h00, (i >= 2 && i <= 5) ? eb : ea});
    end
  endtask

  // waits for a run on one group and checks its length in cycles
  task automatic cal_chk(input bit grp, input int exp_len);
    int n;
    n = 0;
    for (int k = 0;
         k < 8 && !(grp ? term_cal_busy_b : term_cal_busy_a); k++) begin
      @(posedge mclk);
      #1;
    end
    while ((grp ? term_cal_busy_b : term_cal_busy_a) === 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n[7:0], exp_len[7:0]);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic pdiv(input logic [7:0] d, input int div);
    int n;
    n = 0;
    wr(`SRTC_ADDR_PREDIV, d);
    rd_chk(`SRTC_ADDR_PREDIV, d & 8'h03);
    fork
      #512;
      forever begin
        @(posedge ref_div_clk);
        n++;
      end
    join_any
    disable fork;
    chk(8'((n + 1) >> 2), 8'(8 / div));
  endtask

  task automatic t_reset;
    logic [9:0] a [7];
    a = '{`SRTC_ADDR_PREDIV, `SRTC_ADDR_A_START, `SRTC_ADDR_A_OVR,
      `SRTC_ADDR_A_RB, `SRTC_ADDR_B_START, `SRTC_ADDR_B_OVR, 10'h2b3};
    foreach (a[i]) rd_chk(a[i], `SRTC_RST_VAL);
    lanes_chk(3'h0, 3'h0);
    chk({6'h00, term_cal_busy_a, term_cal_busy_b}, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_prediv;
    pdiv(8'hfc, 4);
    pdiv(8'h01, 2);
    pdiv(8'hfe, 1);
    pdiv(8'h03, 4);
    $display("prediv test done");
  endtask

  task automatic t_cal;
    wr(`SRTC_ADDR_A_START, 8'h01);
    cal_chk(1'b0, 33);
    rd_chk(`SRTC_ADDR_A_RB, 8'h05);
    lanes_chk(3'h5, 3'h0);
    term_cal_result_a <= 3'h2;
    wr(`SRTC_ADDR_A_START, 8'h01);
    cal_chk(1'b0, 0);
    rd_chk(`SRTC_ADDR_A_RB, 8'h05);
    wr(`SRTC_ADDR_A_START, 8'h00);
    wr(`SRTC_ADDR_A_START, 8'h01);
    cal_chk(1'b0, 33);
    rd_chk(`SRTC_ADDR_A_RB, 8'h02);
    wr(`SRTC_ADDR_A_RB, 8'h0f);
    rd_chk(`SRTC_ADDR_A_RB, 8'h02);
    wr(`SRTC_ADDR_B_START, 8'h01);
    cal_chk(1'b1, 33);
    lanes_chk(3'h2, 3'h3);
    $display("calibration test done");
  endtask

  task automatic t_override;
    for (int v = 0; v < 8; v++) begin
      wr(`SRTC_ADDR_A_OVR, {3'h0, 1'b1, 3'(v), 1'b1});
      wr(`SRTC_ADDR_B_OVR, {3'h7, 1'b1, 3'(7 - v), 1'b0});
      repeat (2) @(posedge mclk);
      #1;
      lanes_chk(3'(v), 3'(7 - v));
    end
    rd_chk(`SRTC_ADDR_A_OVR, 8'h1f);
    wr(`SRTC_ADDR_A_OVR, 8'hee);
    wr(`SRTC_ADDR_B_OVR, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    lanes_chk(3'h2, 3'h3);
    rd_chk(`SRTC_ADDR_A_OVR, 8'hee);
    $display("override test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_prediv();
    t_cal();
    t_override();
    wrap_up();
  end
endmodule
